// File: rtl/cfa_core.sv
`timescale 1ns/1ps
`default_nettype none
module cfa_core #(
  parameter int MULT_CYCLES = cfa_pkg::MULT_CYCLES
) (
  input  wire logic                     i_clk,
  input  wire logic                     i_nrst,
  input  wire logic                     i_ce,
  input  wire logic                     i_start,
  input  wire cfa_pkg::cfa_ins_t        i_ins,
  input  wire logic [7:0]               i_acc,
  input  wire logic [7:0]               i_idx,
  input  wire logic [15:0]              i_pc_next,
  input  wire logic                     i_half,
  input  wire logic                     i_imask,
  input  wire logic                     i_irq_pin,
  input  wire logic                     i_mem_ack,
  input  wire logic [7:0]               i_mem_rdata,
  output logic                          o_ready,
  output logic                          o_mem_rd,
  output logic [15:0]                   o_addr,
  output logic                          o_done,
  output logic                          o_illegal,
  output var cfa_pkg::cfa_mode_t        o_mode,
  output logic [1:0]                    o_len,
  output var cfa_pkg::cfa_flags_t       o_flags,
  output var cfa_pkg::cfa_res_t         o_res,
  output var cfa_pkg::cfa_flow_t        o_flow
);

  typedef struct packed {
    cfa_pkg::cfa_state_t st;
    logic                irq_s1;
    logic                irq_s2;
    cfa_pkg::cfa_ins_t   ins;
    logic [15:0]         addr;
    cfa_pkg::cfa_mode_t  mode;
    logic [1:0]          len;
    logic                done;
    logic                illegal;
    cfa_pkg::cfa_flags_t flags;
    cfa_pkg::cfa_res_t   res;
    cfa_pkg::cfa_flow_t  flow;
  } cfa_core_state_t;

  cfa_core_state_t     s_ff;
  cfa_core_state_t     nxt_s;
  cfa_pkg::cfa_ins_t   cur;
  cfa_pkg::cfa_dec_t   d;
  logic [15:0]         addr;
  logic                needs_read;
  logic                is_mult;
  logic                mult_start;
  logic                mult_done;
  logic [7:0]          mult_hi;
  logic [7:0]          mult_lo;
  logic [7:0]          opnd;
  logic [7:0]          rmw_v;
  logic [7:0]          add_a;
  logic [7:0]          add_b;
  logic                add_cin;
  logic                borrow;
  logic [8:0]          sum;
  logic                carry;
  logic [7:0]          mask;
  logic [7:0]          e_val;
  logic                e_nz;
  logic                e_wr_rmw;
  cfa_pkg::cfa_flags_t e_flags;
  cfa_pkg::cfa_res_t   e_res;
  cfa_pkg::cfa_flow_t  e_flow;

  function automatic cfa_pkg::cfa_dec_t decode(input cfa_pkg::cfa_ins_t ins);
    cfa_pkg::cfa_dec_t dd;
    logic [4:0]        f;
    logic              alu;
    logic              rmw;
    logic              ctl;
    dd         = '0;
    f          = ins.opcode[cfa_pkg::OPC_FN_W-1:0];
    dd.mode    = cfa_pkg::cfa_mode_t'(ins.opcode[7:cfa_pkg::OPC_GRP_LSB]);
    dd.op      = cfa_pkg::cfa_op_t'(f);
    dd.cond    = cfa_pkg::cfa_cond_t'(f[3:0]);
    dd.misc    = cfa_pkg::cfa_inh_t'(f);
    alu        = (f <= 5'(cfa_pkg::op_load_idx));
    rmw        = (f >= 5'(cfa_pkg::op_shl)) && (f <= 5'(cfa_pkg::op_test));
    ctl        = alu || (f == 5'(cfa_pkg::op_store_acc)) || (f == 5'(cfa_pkg::op_store_idx))
                 || (f == 5'(cfa_pkg::op_jump)) || (f == 5'(cfa_pkg::op_call));
    case (dd.mode)
      cfa_pkg::mode_inh: begin
        dd.len     = cfa_pkg::LEN_1;
        dd.is_misc = (f <= 5'(cfa_pkg::inh_idx_to_acc));
        dd.legal   = dd.is_misc || rmw;
      end
      cfa_pkg::mode_rel: begin
        if (f[cfa_pkg::OPC_XFORM] && (f[3:0] <= cfa_pkg::XFORM_LAST)) begin
          // index-register forms of shift/rotate/clear/etc live in spare relative codes
          dd.mode   = cfa_pkg::mode_inh;
          dd.op     = cfa_pkg::cfa_op_t'(5'(cfa_pkg::op_shl) + {1'b0, f[3:0]});
          dd.on_idx = 1'b1;
          dd.len    = cfa_pkg::LEN_1;
          dd.legal  = 1'b1;
        end else begin
          dd.rel_call = f[cfa_pkg::OPC_XFORM];
          dd.len      = cfa_pkg::LEN_2;
          dd.legal    = !f[cfa_pkg::OPC_XFORM] || (f[3:0] == cfa_pkg::REL_CALL_IDX);
        end
      end
      cfa_pkg::mode_imm: begin
        dd.len   = cfa_pkg::LEN_2;
        dd.legal = alu;
      end
      cfa_pkg::mode_dir: begin
        dd.legal = (f <= 5'(cfa_pkg::op_call));
        dd.len   = ((f == 5'(cfa_pkg::branch_on_bit_set_op)) || (f == 5'(cfa_pkg::branch_on_bit_clear_op)))
                   ? cfa_pkg::LEN_3 : cfa_pkg::LEN_2;
      end
      cfa_pkg::mode_ext: begin
        dd.len   = cfa_pkg::LEN_3;
        dd.legal = ctl;
      end
      cfa_pkg::mode_ix0: begin
        dd.len   = cfa_pkg::LEN_1;
        dd.legal = ctl || rmw;
      end
      cfa_pkg::mode_ix1: begin
        dd.len   = cfa_pkg::LEN_2;
        dd.legal = ctl || rmw;
      end
      default: begin
        dd.len   = cfa_pkg::LEN_3;
        dd.legal = ctl;
      end
    endcase
    return dd;
  endfunction

  function automatic logic cond_ok(input cfa_pkg::cfa_cond_t c, input cfa_pkg::cfa_flags_t fl,
                                   input logic half, input logic imask, input logic irq);
    logic r;
    case (c)
      cfa_pkg::c_always:     r = 1'b1;
      cfa_pkg::c_never:      r = 1'b0;
      cfa_pkg::c_higher:     r = !(fl.c || fl.z);
      cfa_pkg::c_lower_same: r = fl.c || fl.z;
      cfa_pkg::c_carry_clr:  r = !fl.c;
      cfa_pkg::c_carry_set:  r = fl.c;
      cfa_pkg::c_not_equal:  r = !fl.z;
      cfa_pkg::c_equal:      r = fl.z;
      cfa_pkg::c_half_clr:   r = !half;
      cfa_pkg::c_half_set:   r = half;
      cfa_pkg::c_plus:       r = !fl.n;
      cfa_pkg::c_minus:      r = fl.n;
      cfa_pkg::c_mask_clr:   r = !imask;
      cfa_pkg::c_mask_set:   r = imask;
      cfa_pkg::c_irq_low:    r = !irq;
      default:               r = irq;
    endcase
    return r;
  endfunction

  // the caller must hold i_acc and i_idx steady until o_done; i_ins is registered at start
  assign cur = (s_ff.st == cfa_pkg::st_idle) ? i_ins : s_ff.ins;
  assign d   = decode(cur);

  always_comb begin
    case (d.mode)
      cfa_pkg::mode_dir: addr = {cfa_pkg::PAGE0_HI, cur.byte1};
      cfa_pkg::mode_ext: addr = {cur.byte1, cur.byte2};
      cfa_pkg::mode_ix0: addr = {cfa_pkg::PAGE0_HI, i_idx};
      cfa_pkg::mode_ix1: addr = {cfa_pkg::PAGE0_HI, cur.byte1} + {cfa_pkg::PAGE0_HI, i_idx};
      cfa_pkg::mode_ix2: addr = {cur.byte1, cur.byte2} + {cfa_pkg::PAGE0_HI, i_idx};
      default:           addr = 16'h0000;
    endcase
  end

  assign is_mult    = d.is_misc && (d.misc == cfa_pkg::unsigned_multiply_op);
  assign needs_read = (d.mode != cfa_pkg::mode_inh) && (d.mode != cfa_pkg::mode_rel)
                      && (d.mode != cfa_pkg::mode_imm)
                      && (d.op != cfa_pkg::op_store_acc) && (d.op != cfa_pkg::op_store_idx)
                      && (d.op != cfa_pkg::op_jump) && (d.op != cfa_pkg::op_call);
  assign mult_start = (s_ff.st == cfa_pkg::st_idle) && i_start && d.legal && is_mult;
  assign opnd       = (d.mode == cfa_pkg::mode_imm) ? cur.byte1 : i_mem_rdata;
  assign rmw_v      = (d.mode == cfa_pkg::mode_inh) ? (d.on_idx ? i_idx : i_acc) : opnd;
  assign mask       = 8'h01 << cur.bit_sel;

  // one adder serves add, subtract, compare and negate
  always_comb begin
    add_a   = i_acc;
    add_b   = opnd;
    add_cin = 1'b0;
    borrow  = 1'b0;
    case (d.op)
      cfa_pkg::op_add_carry: add_cin = s_ff.flags.c;
      cfa_pkg::op_sub, cfa_pkg::op_cmp_acc: begin
        add_b   = ~opnd;
        add_cin = 1'b1;
        borrow  = 1'b1;
      end
      cfa_pkg::op_cmp_idx: begin
        add_a   = i_idx;
        add_b   = ~opnd;
        add_cin = 1'b1;
        borrow  = 1'b1;
      end
      cfa_pkg::op_sub_carry: begin
        add_b   = ~opnd;
        add_cin = ~s_ff.flags.c;
        borrow  = 1'b1;
      end
      cfa_pkg::op_neg: begin
        add_a   = 8'h00;
        add_b   = ~rmw_v;
        add_cin = 1'b1;
        borrow  = 1'b1;
      end
      default: ;
    endcase
    sum   = {1'b0, add_a} + {1'b0, add_b} + {8'h00, add_cin};
    carry = sum[8] ^ borrow;
  end

  always_comb begin
    e_flags         = s_ff.flags;
    e_res           = '0;
    e_res.acc       = i_acc;
    e_res.idx       = i_idx;
    e_flow          = '0;
    e_flow.ctl      = d.misc;
    e_val           = 8'h00;
    e_nz            = 1'b0;
    e_wr_rmw        = 1'b0;
    if (d.is_misc) begin
      case (d.misc)
        cfa_pkg::inh_set_carry: e_flags.c = 1'b1;
        cfa_pkg::inh_clr_carry: e_flags.c = 1'b0;
        cfa_pkg::inh_acc_to_idx: begin
          e_res.idx    = i_acc;
          e_res.idx_we = 1'b1;
        end
        cfa_pkg::inh_idx_to_acc: begin
          e_res.acc    = i_idx;
          e_res.acc_we = 1'b1;
        end
        default: e_flow.ctl_valid = 1'b1;
      endcase
    end else if (d.mode == cfa_pkg::mode_rel) begin
      e_flow.branch = d.rel_call || cond_ok(d.cond, s_ff.flags, i_half, i_imask, s_ff.irq_s2);
      e_flow.call   = d.rel_call;
      e_flow.target = e_flow.branch ? i_pc_next + {{8{cur.byte1[7]}}, cur.byte1} : i_pc_next;
    end else begin
      case (d.op)
        cfa_pkg::op_add, cfa_pkg::op_add_carry, cfa_pkg::op_sub, cfa_pkg::op_sub_carry: begin
          e_val        = sum[7:0];
          e_nz         = 1'b1;
          e_flags.c    = carry;
          e_res.acc    = sum[7:0];
          e_res.acc_we = 1'b1;
        end
        cfa_pkg::op_cmp_acc, cfa_pkg::op_cmp_idx: begin
          e_val     = sum[7:0];
          e_nz      = 1'b1;
          e_flags.c = carry;
        end
        cfa_pkg::op_and, cfa_pkg::op_or, cfa_pkg::op_xor: begin
          e_val        = (d.op == cfa_pkg::op_and) ? (i_acc & opnd)
                       : (d.op == cfa_pkg::op_or) ? (i_acc | opnd) : (i_acc ^ opnd);
          e_nz         = 1'b1;
          e_res.acc    = e_val;
          e_res.acc_we = 1'b1;
        end
        cfa_pkg::op_bit_test: begin
          e_val = i_acc & opnd;
          e_nz  = 1'b1;
        end
        cfa_pkg::op_load_acc: begin
          e_val        = opnd;
          e_nz         = 1'b1;
          e_res.acc    = opnd;
          e_res.acc_we = 1'b1;
        end
        cfa_pkg::op_load_idx: begin
          e_val        = opnd;
          e_nz         = 1'b1;
          e_res.idx    = opnd;
          e_res.idx_we = 1'b1;
        end
        cfa_pkg::op_store_acc, cfa_pkg::op_store_idx: begin
          e_val           = (d.op == cfa_pkg::op_store_acc) ? i_acc : i_idx;
          e_nz            = 1'b1;
          e_res.mem_wdata = e_val;
          e_res.mem_we    = 1'b1;
        end
        cfa_pkg::op_shl: begin
          e_val     = {rmw_v[6:0], 1'b0};
          e_flags.c = rmw_v[7];
        end
        cfa_pkg::op_shr_arith: begin
          e_val     = {rmw_v[7], rmw_v[7:1]};
          e_flags.c = rmw_v[0];
        end
        cfa_pkg::op_shr: begin
          e_val     = {1'b0, rmw_v[7:1]};
          e_flags.c = rmw_v[0];
        end
        cfa_pkg::op_rol: begin
          e_val     = {rmw_v[6:0], s_ff.flags.c};
          e_flags.c = rmw_v[7];
        end
        cfa_pkg::op_ror: begin
          e_val     = {s_ff.flags.c, rmw_v[7:1]};
          e_flags.c = rmw_v[0];
        end
        cfa_pkg::op_clear: e_val = 8'h00;
        cfa_pkg::op_compl: e_val = ~rmw_v;
        cfa_pkg::op_inc:   e_val = rmw_v + 8'h01;
        cfa_pkg::op_dec:   e_val = rmw_v - 8'h01;
        cfa_pkg::op_neg: begin
          e_val     = sum[7:0];
          e_flags.c = carry;
        end
        cfa_pkg::op_test: e_val = rmw_v;
        cfa_pkg::op_bit_set, cfa_pkg::op_bit_clear: begin
          e_res.mem_wdata = (d.op == cfa_pkg::op_bit_set) ? (opnd | mask) : (opnd & ~mask);
          e_res.mem_we    = 1'b1;
        end
        cfa_pkg::branch_on_bit_set_op, cfa_pkg::branch_on_bit_clear_op: begin
          e_flags.c     = opnd[cur.bit_sel];
          e_flow.branch = (d.op == cfa_pkg::branch_on_bit_set_op) ? opnd[cur.bit_sel] : !opnd[cur.bit_sel];
          e_flow.target = e_flow.branch ? i_pc_next + {{8{cur.byte2[7]}}, cur.byte2} : i_pc_next;
        end
        cfa_pkg::op_jump, cfa_pkg::op_call: begin
          e_flow.jump   = 1'b1;
          e_flow.call   = (d.op == cfa_pkg::op_call);
          e_flow.target = addr;
        end
        default: ;
      endcase
      if ((d.op >= cfa_pkg::op_shl) && (d.op <= cfa_pkg::op_test)) begin
        e_nz     = 1'b1;
        e_wr_rmw = (d.op != cfa_pkg::op_test);
      end
    end
    if (e_nz) begin
      e_flags.n = e_val[7];
      e_flags.z = (e_val == 8'h00);
    end
    if (e_wr_rmw) begin
      if (d.mode != cfa_pkg::mode_inh) begin
        e_res.mem_wdata = e_val;
        e_res.mem_we    = 1'b1;
      end else if (d.on_idx) begin
        e_res.idx    = e_val;
        e_res.idx_we = 1'b1;
      end else begin
        e_res.acc    = e_val;
        e_res.acc_we = 1'b1;
      end
    end
  end

  always_comb begin
    nxt_s         = s_ff;
    nxt_s.irq_s1  = i_irq_pin;
    nxt_s.irq_s2  = s_ff.irq_s1;
    nxt_s.done    = 1'b0;
    nxt_s.illegal = 1'b0;
    nxt_s.res     = '0;
    nxt_s.flow    = '0;
    case (s_ff.st)
      cfa_pkg::st_idle: begin
        if (i_start) begin
          nxt_s.ins  = i_ins;
          nxt_s.addr = addr;
          nxt_s.mode = d.mode;
          nxt_s.len  = d.len;
          if (!d.legal) begin
            nxt_s.done    = 1'b1;
            nxt_s.illegal = 1'b1;
          end else if (is_mult) begin
            nxt_s.st = cfa_pkg::st_mult;
          end else if (needs_read) begin
            nxt_s.st = cfa_pkg::st_read;
          end else begin
            nxt_s.done  = 1'b1;
            nxt_s.flags = e_flags;
            nxt_s.res   = e_res;
            nxt_s.flow  = e_flow;
          end
        end
      end
      cfa_pkg::st_read: begin
        if (i_mem_ack) begin
          nxt_s.st    = cfa_pkg::st_idle;
          nxt_s.done  = 1'b1;
          nxt_s.flags = e_flags;
          nxt_s.res   = e_res;
          nxt_s.flow  = e_flow;
        end
      end
      default: begin
        if (mult_done) begin
          // flags are left as they were: multiply defines none here
          nxt_s.st         = cfa_pkg::st_idle;
          nxt_s.done       = 1'b1;
          nxt_s.res.acc    = mult_lo;
          nxt_s.res.idx    = mult_hi;
          nxt_s.res.acc_we = 1'b1;
          nxt_s.res.idx_we = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_ff       <= '0;
      s_ff.flags <= cfa_pkg::FLAGS_RST;
    end else if (i_ce) begin
      s_ff <= nxt_s;
    end
  end

  cfa_multiplier #(
    .W      (cfa_pkg::DATA_W),
    .CYCLES (MULT_CYCLES)
  ) u_mult (
    .i_clk   (i_clk),
    .i_nrst  (i_nrst),
    .i_ce    (i_ce),
    .i_start (mult_start),
    .i_a     (i_acc),
    .i_b     (i_idx),
    .o_done  (mult_done),
    .o_hi    (mult_hi),
    .o_lo    (mult_lo)
  );

  assign o_ready   = (s_ff.st == cfa_pkg::st_idle);
  assign o_mem_rd  = (s_ff.st == cfa_pkg::st_read);
  assign o_addr    = s_ff.addr;
  assign o_done    = s_ff.done;
  assign o_illegal = s_ff.illegal;
  assign o_mode    = s_ff.mode;
  assign o_len     = s_ff.len;
  assign o_flags   = s_ff.flags;
  assign o_res     = s_ff.res;
  assign o_flow    = s_ff.flow;

endmodule // cfa_core
`default_nettype wire

// File: rtl/cfa_pkg.sv
`default_nettype none
package cfa_pkg;

  localparam int DATA_W      = 8;
  localparam int ADDR_W      = 16;
  localparam int MULT_CYCLES = 11;

  // opcode byte layout: {group[2:0], function[4:0]}
  localparam int OPC_GRP_LSB = 5;
  localparam int OPC_FN_W    = 5;
  localparam int OPC_XFORM   = 4;
  localparam logic [3:0] XFORM_LAST   = 4'ha;
  localparam logic [3:0] REL_CALL_IDX = 4'hb;
  localparam logic [7:0] PAGE0_HI     = 8'h00;

  localparam logic [1:0] LEN_1 = 2'h1;
  localparam logic [1:0] LEN_2 = 2'h2;
  localparam logic [1:0] LEN_3 = 2'h3;

  localparam logic [2:0] FLAGS_RST = 3'h0;

  typedef enum logic [2:0] {
    mode_inh, mode_imm, mode_dir, mode_ext, mode_ix0, mode_ix1, mode_ix2, mode_rel
  } cfa_mode_t;

  typedef enum logic [4:0] {
    op_add, op_add_carry, op_sub, op_sub_carry, op_and, op_or, op_xor, op_bit_test,
    op_cmp_acc, op_cmp_idx, op_load_acc, op_load_idx, op_store_acc, op_store_idx,
    op_shl, op_shr_arith, op_shr, op_rol, op_ror, op_clear, op_compl, op_inc, op_dec,
    op_neg, op_test, op_bit_set, op_bit_clear, branch_on_bit_set_op, branch_on_bit_clear_op,
    op_jump, op_call, op_none
  } cfa_op_t;

  typedef enum logic [4:0] {
    unsigned_multiply_op, inh_nop, inh_stack_reset, inh_ret_int, inh_ret_sub, inh_soft_int,
    inh_stop, inh_wait, inh_set_carry, inh_clr_carry, inh_set_mask, inh_clr_mask,
    inh_acc_to_idx, inh_idx_to_acc
  } cfa_inh_t;

  typedef enum logic [3:0] {
    c_always, c_never, c_higher, c_lower_same, c_carry_clr, c_carry_set, c_not_equal,
    c_equal, c_half_clr, c_half_set, c_plus, c_minus, c_mask_clr, c_mask_set,
    c_irq_low, c_irq_high
  } cfa_cond_t;

  typedef enum logic [1:0] {
    st_idle, st_read, st_mult
  } cfa_state_t;

  typedef struct packed {
    logic [7:0] opcode;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic [2:0] bit_sel;
  } cfa_ins_t;

  typedef struct packed {
    logic n;
    logic z;
    logic c;
  } cfa_flags_t;

  typedef struct packed {
    logic [DATA_W-1:0] acc;
    logic [DATA_W-1:0] idx;
    logic [DATA_W-1:0] mem_wdata;
    logic              acc_we;
    logic              idx_we;
    logic              mem_we;
  } cfa_res_t;

  typedef struct packed {
    logic              branch;
    logic              jump;
    logic              call;
    logic [ADDR_W-1:0] target;
    logic              ctl_valid;
    cfa_inh_t          ctl;
  } cfa_flow_t;

  typedef struct packed {
    cfa_mode_t  mode;
    cfa_op_t    op;
    cfa_cond_t  cond;
    cfa_inh_t   misc;
    logic       is_misc;
    logic       on_idx;
    logic       rel_call;
    logic       legal;
    logic [1:0] len;
  } cfa_dec_t;

endpackage
`default_nettype wire

// File: rtl/cfa_multiplier.sv
`timescale 1ns/1ps
`default_nettype none
module cfa_multiplier #(
  parameter int W      = 8,
  parameter int CYCLES = 11
) (
  input  wire logic           i_clk,
  input  wire logic           i_nrst,
  input  wire logic           i_ce,
  input  wire logic           i_start,
  input  wire logic [W-1:0]   i_a,
  input  wire logic [W-1:0]   i_b,
  output logic                o_done,
  output logic [W-1:0]        o_hi,
  output logic [W-1:0]        o_lo
);

  localparam int CNT_W = $clog2(CYCLES + 1);
  // the core registers done one edge after ours, so finish one edge early to keep the total at CYCLES
  localparam logic [CNT_W-1:0] CNT_LAST  = CNT_W'(CYCLES - 2);
  localparam logic [CNT_W-1:0] CNT_STEPS = CNT_W'(W);

  // add/shift chain needs W steps plus the load and finish edges
  if (CYCLES < W + 2) begin : g_bad_cycles
    $error("cfa_multiplier: CYCLES too small for W");
  end

  typedef struct packed {
    logic             busy;
    logic             done;
    logic [CNT_W-1:0] cnt;
    logic [W-1:0]     mcand;
    logic [W-1:0]     hi;
    logic [W-1:0]     lo;
  } cfa_mult_state_t;

  cfa_mult_state_t s_ff;
  cfa_mult_state_t nxt_s;
  logic [W:0]      part;

  always_comb begin
    nxt_s      = s_ff;
    nxt_s.done = 1'b0;
    part       = {1'b0, s_ff.hi} + (s_ff.lo[0] ? {1'b0, s_ff.mcand} : '0);
    if (s_ff.busy) begin
      nxt_s.cnt = s_ff.cnt + 1'b1;
      if (s_ff.cnt <= CNT_STEPS) begin
        {nxt_s.hi, nxt_s.lo} = {part, s_ff.lo[W-1:1]};
      end
      if (s_ff.cnt == CNT_LAST) begin
        nxt_s.busy = 1'b0;
        nxt_s.done = 1'b1;
      end
    end else if (i_start) begin
      nxt_s.busy  = 1'b1;
      nxt_s.cnt   = CNT_W'(1);
      nxt_s.mcand = i_a;
      nxt_s.hi    = '0;
      nxt_s.lo    = i_b;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      s_ff <= '0;
    end else if (i_ce) begin
      s_ff <= nxt_s;
    end
  end

  assign o_done = s_ff.done;
  assign o_hi   = s_ff.hi;
  assign o_lo   = s_ff.lo;

endmodule // cfa_multiplier
`default_nettype wire

// File: tb/cfa_core_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module cfa_core_asserts (
  input wire logic                i_clk,
  input wire logic                i_nrst,
  input wire logic                i_ce,
  input wire logic                i_start,
  input wire cfa_pkg::cfa_ins_t   i_ins,
  input wire logic                o_ready,
  input wire logic                o_mem_rd,
  input wire logic [15:0]         o_addr,
  input wire logic                o_done,
  input wire logic                o_illegal,
  input wire cfa_pkg::cfa_flags_t o_flags
);
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  wire logic       take = i_ce && o_ready && i_start;
  wire logic [2:0] grp  = i_ins.opcode[7:5];
  wire logic [4:0] fn   = i_ins.opcode[4:0];
  sequence mul_take; take && i_ins.opcode == 8'h00; endsequence
  sequence mul_run; (!o_ready && !o_done) ##9 (!o_ready && !o_done) ##1 o_done; endsequence
  mult_len_a: assert property (mul_take |=> mul_run)
    else $error("multiply length wrong");
  // counts the cycles of a running multiply so every middle cycle is checked
  logic [3:0] mul_cnt;
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      mul_cnt <= 4'h0;
    end else if (i_ce) begin
      if (take && i_ins.opcode == 8'h00) mul_cnt <= 4'h1;
      else if (mul_cnt != 4'h0) mul_cnt <= (mul_cnt == 4'hb) ? 4'h0 : mul_cnt + 4'h1;
    end
  end
  mult_busy_a: assert property (mul_cnt inside {[4'h1:4'ha]} |-> !o_ready && !o_done)
    else $error("multiply ended early");
  imm_noaddr_a: assert property (take && grp == 3'h1 |=> o_done && o_addr == 16'h0 && !o_mem_rd)
    else $error("immediate formed an address");
  imm_refuse_a: assert property (take && grp == 3'h1 && fn > 5'd11 |=> o_illegal)
    else $error("immediate op not refused");
  dir_addr_a: assert property (take && grp == 3'h2 && fn < 5'd31 |=> o_addr == {8'h00, $past(i_ins.byte1)})
    else $error("direct address wrong");
  ext_addr_a: assert property (take && grp == 3'h3 && fn < 5'd14 |=>
    o_addr == {$past(i_ins.byte1), $past(i_ins.byte2)})
    else $error("extended address wrong");
  ext_refuse_a: assert property (take && grp == 3'h3 && fn inside {[5'd14:5'd28]} |=> o_illegal)
    else $error("extended rmw not refused");
  inh_noread_a: assert property (take && grp == 3'h0 |=> !o_mem_rd && o_addr == 16'h0)
    else $error("inherent read memory");
  // flags may only move on a completing instruction
  flag_hold_a: assert property ($changed(o_flags) |-> o_done)
    else $error("flags moved without done");
endmodule // cfa_core_asserts
bind cfa_core cfa_core_asserts u_chk (.i_clk, .i_nrst, .i_ce, .i_start, .i_ins, .o_ready, .o_mem_rd,
  .o_addr, .o_done, .o_illegal, .o_flags);
`default_nettype wire

// File: tb/cfa_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
module cfa_mem_model (
  input  wire logic        i_clk,
  input  wire logic        i_rd,
  input  wire logic [15:0] i_addr,
  output logic             o_ack,
  output logic [7:0]       o_data
);
  int wait_n = 0;
  initial begin
    o_ack = 0;
    o_data = 8'h0;
  end
  // data toggles off the ack cycle so a late sample never matches by luck
  always @(posedge i_clk) begin
    #1;
    if (i_rd && wait_n == 0) begin
      o_ack = 1;
      o_data = i_addr[7:0] ^ i_addr[15:8] ^ 8'h5a;
      wait_n = $urandom_range(3);
    end else begin
      o_ack = 0;
      o_data = ~o_data;
      if (i_rd) wait_n--;
    end
  end
endmodule // cfa_mem_model
`default_nettype wire

// File: tb/cpu_flags_alu_addressing_test.sv
`timescale 1ns/1ps
`default_nettype none
module cpu_flags_alu_addressing_test;
  logic                i_clk = 0;
  logic                i_nrst = 0;
  logic                start = 0;
  cfa_pkg::cfa_ins_t   ins = '0;
  logic [7:0]          a = 0, x = 0, b, c2, rdat;
  logic                ack, rd, done, ill;
  logic [15:0]         addr;
  logic [1:0]          len;
  cfa_pkg::cfa_mode_t  mode;
  cfa_pkg::cfa_flow_t  flow;
  cfa_pkg::cfa_flags_t fl;
  cfa_pkg::cfa_res_t   res;
  int                  bad_count = 0, checks = 0, cyc = 0, r;
  logic                en = 0, ez = 0, ec = 0;
  logic [4:0]          f;
  logic [4:0]          fns [7] = '{0, 2, 4, 5, 6, 10, 8};
  cfa_core dut (.i_clk, .i_nrst, .i_ce(1'b1), .i_start(start), .i_ins(ins), .i_acc(a), .i_idx(x),
    .i_pc_next(16'h0), .i_half(1'b0), .i_imask(1'b0), .i_irq_pin(1'b0), .i_mem_ack(ack),
    .i_mem_rdata(rdat), .o_ready(), .o_mem_rd(rd), .o_addr(addr), .o_done(done), .o_illegal(ill),
    .o_mode(mode), .o_len(len), .o_flags(fl), .o_res(res), .o_flow(flow));
  cfa_mem_model mem (.i_clk, .i_rd(rd), .i_addr(addr), .o_ack(ack), .o_data(rdat));
  always #50 i_clk = ~i_clk;
  task automatic complete_run;
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] s, e);
    checks++;
    if (s !== e) begin
      bad_count++;
      $display("MISMATCH %0t got %h exp %h", $time, s, e);
    end
  endtask
  task automatic op(input logic [7:0] o, b1, b2);
    int t = 0;
    @(posedge i_clk); #1;
    ins = '{o, b1, b2, 3'h0};
    start = 1;
    @(posedge i_clk); #1;
    start = 0;
    while (done !== 1'b1 && t < 40) begin
      @(posedge i_clk); #1;
      t++;
    end
    chk(done, 1'b1);
  endtask
  task automatic nz(input int v);
    en = v[7];
    ez = v[7:0] == 0;
  endtask
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 6000) begin
      bad_count++;
      complete_run;
    end
  end
  initial begin
    void'($urandom(32'hf7faa745));
    repeat (12) @(posedge i_clk);
    #1 i_nrst = 1;
    for (int k = 0; k < 49; k++) begin
      a = $urandom;
      x = $urandom;
      b = $urandom;
      c2 = $urandom;
      f = fns[k % 7];
      op({3'h1, f}, b, 8'h0);
      case (f)
        0: r = a + b;
        2, 8: r = a - b;
        4: r = a & b;
        5: r = a | b;
        6: r = a ^ b;
        default: r = b;
      endcase
      if (f inside {0, 2, 8}) ec = r[8];
      nz(r);
      chk(res.acc, f == 8 ? a : r[7:0]);
      chk(len, cfa_pkg::LEN_2);
      chk(fl, {en, ez, ec});
      op(8'h00, 8'h0, 8'h0);
      chk({res.idx, res.acc}, a * x);
      chk(fl, {en, ez, ec});
      op(8'h0e, 8'h0, 8'h0);
      ec = a[7];
      nz({a, 1'b0});
      chk(fl, {en, ez, ec});
      chk(len, cfa_pkg::LEN_1);
      op(8'h4a, b, 8'h0);
      nz(b ^ 8'h5a);
      chk(res.acc, b ^ 8'h5a);
      chk(fl, {en, ez, ec});
      chk(mode, cfa_pkg::mode_dir);
      op(8'h5b, b, c2);
      r = b ^ 8'h5a;
      ec = r[0];
      chk(flow.target, ec ? {{8{c2[7]}}, c2} : 16'h0);
      chk(len, cfa_pkg::LEN_3);
      chk(fl, {en, ez, ec});
      op(8'h6a, b, c2);
      nz(b ^ c2 ^ 8'h5a);
      chk(res.acc, b ^ c2 ^ 8'h5a);
      chk(len, cfa_pkg::LEN_3);
      op(8'h2c, b, 8'h0);
      chk(ill, 1'b1);
      op(8'h6e, b, c2);
      chk(ill, 1'b1);
      chk(fl, {en, ez, ec});
      op(8'he0, b, 8'h0);
      chk(flow.target, {{8{b[7]}}, b});
      op(8'he1, b, 8'h0);
      chk(flow.branch, 1'b0);
      chk(flow.target, 16'h0);
    end
    complete_run;
  end
endmodule // cpu_flags_alu_addressing_test
`default_nettype wire
